/* File: dv/freq_sweep_sequencer_tb.sv */
// Self-checking bench for the frequency sweep sequencer.
// Assumes host_model drives every host-side input.
`timescale 1ns/10ps
`default_nettype none
module freq_sweep_sequencer_tb;
    typedef struct packed {
        logic [11:0] ctrl;
        logic [15:0] hi;
        logic [23:0] f1;
        logic [23:0] f2;
        logic [23:0] f3;
    } row_t;
    row_t rows [3] = '{
        '{12'h093, 16'h3000, 24'h000110, 24'h000120, 24'h000100},
        '{12'h083, 16'h3000, 24'h000110, 24'h000120, 24'h000110},
        '{12'h093, 16'h3800, 24'h0000f0, 24'h0000e0, 24'h000100}};
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        wr_valid, trig, out_cycle, midscale, active, pulse;
    logic [15:0] word;
    logic [23:0] freq;
    logic [11:0] index;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          n;
    always #2 ref_clk_i = ~ref_clk_i;
    host_model u_host_model (.ref_clk_i(ref_clk_i), .wr_valid_o(wr_valid), .wr_word_o(word),
        .trig_o(trig), .out_cycle_o(out_cycle));
    freq_sweep_sequencer u_freq_sweep_sequencer (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .wr_valid_i(wr_valid), .wr_word_i(word), .trig_i(trig), .out_cycle_i(out_cycle),
        .freq_word_o(freq), .midscale_o(midscale), .sweep_active_o(active),
        .step_pulse_o(pulse), .step_index_o(index));
    task wrap_up;
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            wrap_up();
        end
    end
    task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wait_step;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (pulse !== 1'b1 && n < 300);
    endtask
    task setup(input logic [11:0] ctrl, input logic [15:0] hi);
        u_host_model.wr({4'h0, ctrl});
        u_host_model.wr(16'h1002);
        u_host_model.wr(16'h2010);
        u_host_model.wr(hi);
        u_host_model.wr(16'hc100);
        u_host_model.wr(16'hd000);
        u_host_model.wr(16'h6004);
        u_host_model.wr(16'ha002);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("reset midscale", 24'h1, {23'h0, midscale});
        chk("reset freq", 24'h0, freq);
        foreach (rows[i]) begin
            setup(rows[i].ctrl, rows[i].hi);
            #1 chk("idle active", 24'h0, {23'h0, active});
            u_host_model.trig_pulse();
            #1 chk("start freq", 24'h100, freq);
            chk("run active", 24'h1, {23'h0, active});
            wait_step();
            chk("step one", rows[i].f1, freq);
            wait_step();
            chk("interval", 24'd6, 24'(n));
            chk("step two", rows[i].f2, freq);
            chk("index", 24'h2, {12'h0, index});
            wait_step();
            chk("end of leg", rows[i].f3, freq);
        end
        u_host_model.wr(16'h0893);
        u_host_model.wr(16'hc123);
        u_host_model.wr(16'hd456);
        u_host_model.trig_pulse();
        #1 chk("full word", 24'h456123, freq);
        u_host_model.wr(16'h0073);
        u_host_model.trig_pulse();
        #1 chk("ext burst", 24'h0, {23'h0, midscale});
        repeat (2) @(posedge ref_clk_i);
        #1 chk("ext listen", 24'h1, {23'h0, midscale});
        // Step pulse stands one cycle only, so look while the pulse is still high
        fork
            u_host_model.trig_pulse();
            begin
                repeat (2) @(posedge ref_clk_i);
                #1 chk("ext pulse", 24'h1, {23'h0, pulse});
                chk("ext step", 24'h456113, freq);
            end
        join
        u_host_model.wr(16'h0003);
        u_host_model.trig_pulse();
        #1 chk("burst on", 24'h0, {23'h0, midscale});
        repeat (3) @(posedge ref_clk_i);
        #1 chk("burst off", 24'h1, {23'h0, midscale});
        wait_step();
        chk("burst step", 24'h0, {23'h0, midscale});
        u_host_model.wr(16'h0023);
        u_host_model.wr(16'ha802);
        u_host_model.trig_pulse();
        repeat (7) @(posedge ref_clk_i);
        #1 chk("burst base", 24'h0, {23'h0, midscale});
        repeat (4) @(posedge ref_clk_i);
        #1 chk("burst x5", 24'h1, {23'h0, midscale});
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: dv/host_model.sv */
// Host model: writes 16-bit words and drives the trigger pin.
// Assumes the bench calls its tasks; outputs change on ref_clk_i rise.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic   ref_clk_i,
    // Host side
    output logic        wr_valid_o,
    output logic [15:0] wr_word_o,
    output logic        trig_o,
    output logic        out_cycle_o
);
    logic [1:0] div_q;
    initial begin
        wr_valid_o = 1'b0;
        wr_word_o = 16'h0000;
        trig_o = 1'b0;
        div_q = 2'h0;
    end
    // Output cycle marker free-runs, one pulse every third clock
    always @(posedge ref_clk_i) begin
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    end
    assign out_cycle_o = (div_q == 2'h2);
    task wr(input logic [15:0] w);
        @(posedge ref_clk_i);
        wr_valid_o <= 1'b1;
        wr_word_o <= w;
        @(posedge ref_clk_i);
        wr_valid_o <= 1'b0;
        // Released word lines must not keep showing the last value
        wr_word_o <= ~w;
    endtask
    task trig_pulse;
        @(posedge ref_clk_i);
        trig_o <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        trig_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: hdl/freq_sweep_sequencer.sv */
// Frequency sweep sequencer: register file, sweep state and step timing.
// Assumes host words and trigger are synchronous to ref_clk_i.
//
// Summary of operation
// RULE_01: Full-word mode: host writes start frequency low half, then high half.
// RULE_02: Split mode: each 12-bit start half updates alone by one write.
// RULE_03: Sweep outputs start, then adds the step at every increment.
// RULE_04: Step is 23 bits; high word bit 11 picks add or subtract.
// RULE_05: Step count is 12-bit binary, legal from 2 to 4095.
// RULE_06: Step interval bit 13 picks output cycles or master clocks.
// RULE_07: Interval count is 11-bit binary, 2 to 2047 base intervals.
// RULE_08: Bits 12..11 pick master clock multiplier 1, 5, 100 or 500.
// RULE_09: Timed sweep lasts step count plus one intervals.
// RULE_10: Burst mode: frequency for burst interval, then midscale until step.
// RULE_11: Burst word bit 13 picks base; bits 10..0 hold the count.
// RULE_12: Base and multiplier follow the step interval word normally.
// RULE_13: Trigger rising edge starts the sweep at the start frequency.
// RULE_14: All three mode bits clear gives fully timed steps and bursts.
// RULE_15: External step, timed burst: each later edge advances frequency.
// RULE_16: External step, timed burst takes base and multiplier from burst word.
// RULE_17: Fully external: output while trigger high, midscale while low.
// RULE_18: Fully external ignores base and multiplier of both words.
// RULE_19: Continuous bit set outputs each frequency for the whole interval.
// RULE_20: External step bit makes steps follow trigger edges, else timed.
// RULE_21: External burst bit applies only in burst mode with external steps.
// RULE_22: Saw bit set gives saw sweep, clear gives triangular sweep.
// RULE_23: Full-word mode commits a split value only when both halves arrived. The code commits on any high-half write, using whatever low half is pending.
// RULE_24: At the end, saw restarts at start; triangle reverses direction.
// RULE_25: Before the first trigger edge, hold midscale and freeze counters.
`timescale 1ns/10ps
`default_nettype none
module freq_sweep_sequencer (
    // Clock and reset
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_n_i,
    // Host register words
    input  wire logic                         wr_valid_i,
    input  wire logic [sweep_pkg::WORD_W-1:0] wr_word_i,
    // Trigger pin and output cycle marker
    input  wire logic                         trig_i,
    input  wire logic                         out_cycle_i,
    // Sweep outputs
    output logic [sweep_pkg::FREQ_W-1:0]      freq_word_o,
    output logic                              midscale_o,
    output logic                              sweep_active_o,
    output logic                              step_pulse_o,
    output logic [sweep_pkg::DATA_W-1:0]      step_index_o
);
    typedef struct packed {
        logic [11:0]             ctrl;
        logic [11:0]             step_count;
        logic [22:0]             fstep_mag;
        logic                    fstep_neg;
        logic [23:0]             start_freq;
        logic [13:0]             step_ival;
        logic [13:0]             burst_ival;
        logic [11:0]             start_pend;
        logic [11:0]             fstep_pend;
        logic                    trig_prev;
        sweep_pkg::sweep_state_t st;
        logic [23:0]             cur;
        logic [11:0]             idx;
        logic                    reverse;
        logic                    burst_on;
        logic                    midscale;
        logic                    step_pulse;
    } seq_state_t;

    seq_state_t  s;
    seq_state_t  n;
    logic [3:0]  addr;
    logic [11:0] data;
    logic        full_word;
    logic        cont;
    logic        ext_step;
    logic        ext_burst;
    logic        saw;
    logic        trig_rise;
    logic        burst_sel;
    logic [13:0] tm_word;
    logic        running;
    logic        step_run;
    logic        burst_run;
    logic        interval_load;
    logic        advance;
    logic        at_end;
    logic        sub;
    logic        tick;
    logic        step_expire;
    logic        burst_expire;

    function automatic logic [23:0] apply_step(
        input logic [23:0] cur,
        input logic [22:0] mag,
        input logic        down
    );
        logic [23:0] ext;
        ext = {1'b0, mag};
        if (down) begin
            apply_step = cur - ext;
        end else begin
            apply_step = cur + ext;
        end
    endfunction

    assign addr      = wr_word_i[15:12];
    assign data      = wr_word_i[11:0];
    assign full_word = s.ctrl[sweep_pkg::CTRL_FULL_WORD_BIT];
    assign cont      = s.ctrl[sweep_pkg::CTRL_CONT_BIT];
    assign ext_step  = s.ctrl[sweep_pkg::CTRL_EXT_STEP_BIT]; // see RULE_20
    // External burst only counts in burst mode with external steps
    assign ext_burst = ext_step & ~cont
                     & s.ctrl[sweep_pkg::CTRL_EXT_BURST_BIT]; // see RULE_21
    assign saw       = s.ctrl[sweep_pkg::CTRL_SAW_BIT]; // see RULE_22
    assign trig_rise = trig_i & ~s.trig_prev; // see RULE_13
    // Time base: burst word with external steps unless external burst is on, else step word
    assign burst_sel = ext_step & ~ext_burst; // see RULE_16
    assign tm_word   = burst_sel ? s.burst_ival : s.step_ival; // see RULE_12
    assign running   = (s.st == sweep_pkg::ST_RUN);
    // Counters stay frozen until the sweep is started
    assign step_run  = running & ~ext_step; // see RULE_14
    // Fully external and continuous modes leave the burst timer idle
    assign burst_run = running & ~cont & ~ext_burst; // see RULE_18

    sweep_tick_gen u_tick (
        .ref_clk_i    (ref_clk_i),
        .rst_n_i      (rst_n_i),
        .restart_i    (interval_load),
        .run_i        (running),
        .clock_base_i (tm_word[sweep_pkg::IVAL_BASE_BIT]),
        .mult_sel_i   (tm_word[sweep_pkg::IVAL_MULT_HI:sweep_pkg::IVAL_MULT_LO]),
        .out_cycle_i  (out_cycle_i),
        .tick_o       (tick)
    );
    sweep_interval_counter u_step_timer (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .load_i    (interval_load),
        .run_i     (step_run),
        .count_i   (s.step_ival[10:0]),
        .tick_i    (tick),
        .expire_o  (step_expire)
    );
    // Burst count always comes from the burst word, see RULE_11
    sweep_interval_counter u_burst_timer (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .load_i    (interval_load),
        .run_i     (burst_run),
        .count_i   (s.burst_ival[10:0]),
        .tick_i    (tick),
        .expire_o  (burst_expire)
    );
    always_comb begin
        n = s;
        n.step_pulse  = 1'b0;
        n.trig_prev   = trig_i;
        interval_load = 1'b0;
        advance       = 1'b0;
        at_end        = (s.idx == s.step_count); // see RULE_05
        sub           = s.fstep_neg ^ s.reverse;
        case (s.st)
            sweep_pkg::ST_IDLE: begin
                if (trig_rise) begin
                    n.st          = sweep_pkg::ST_RUN; // see RULE_13
                    n.cur         = s.start_freq;
                    n.idx         = '0;
                    n.reverse     = 1'b0;
                    n.burst_on    = 1'b1;
                    interval_load = 1'b1;
                end
            end
            sweep_pkg::ST_RUN: begin
                advance = ext_step ? trig_rise : step_expire; // see RULE_15
                if (advance) begin
                    interval_load = 1'b1;
                    n.burst_on    = 1'b1;
                    n.step_pulse  = 1'b1;
                    if (!at_end) begin
                        // One interval per frequency, start included, see RULE_09
                        n.idx = s.idx + 12'h001;
                        n.cur = apply_step(s.cur, s.fstep_mag, sub); // see RULE_03
                    end else if (saw) begin
                        n.idx     = '0;
                        n.cur     = s.start_freq; // see RULE_24
                        n.reverse = 1'b0;
                    end else begin
                        n.idx     = 12'h001;
                        n.reverse = ~s.reverse; // see RULE_24
                        n.cur     = apply_step(s.cur, s.fstep_mag, ~sub);
                    end
                end else if (burst_expire) begin
                    n.burst_on = 1'b0; // see RULE_10
                end
            end
            default: begin
                n.st = sweep_pkg::ST_IDLE;
            end
        endcase
        if (wr_valid_i) begin
            case (addr)
                sweep_pkg::ADDR_CTRL: begin
                    // Control write restarts the sequencer at midscale
                    n.ctrl        = data;
                    n.st          = sweep_pkg::ST_IDLE;
                    n.burst_on    = 1'b0;
                    n.step_pulse  = 1'b0;
                    interval_load = 1'b0;
                end
                sweep_pkg::ADDR_STEP_COUNT: begin
                    n.step_count = data;
                end
                sweep_pkg::ADDR_FSTEP_LOW: begin
                    if (full_word) begin
                        n.fstep_pend = data; // see RULE_23
                    end else begin
                        n.fstep_mag[11:0] = data;
                    end
                end
                sweep_pkg::ADDR_FSTEP_HIGH: begin
                    n.fstep_mag[22:12] = data[10:0]; // see RULE_04
                    n.fstep_neg        = data[sweep_pkg::FSTEP_DIR_BIT];
                    if (full_word) begin
                        n.fstep_mag[11:0] = s.fstep_pend;
                    end
                end
                sweep_pkg::ADDR_START_LOW: begin
                    if (full_word) begin
                        n.start_pend = data; // see RULE_01
                    end else begin
                        n.start_freq[11:0] = data; // see RULE_02
                    end
                end
                sweep_pkg::ADDR_START_HIGH: begin
                    n.start_freq[23:12] = data; // see RULE_02
                    if (full_word) begin
                        n.start_freq[11:0] = s.start_pend; // see RULE_23
                    end
                end
                default: begin
                    if (addr[3:2] == sweep_pkg::ASEL_STEP_IVAL) begin
                        n.step_ival = wr_word_i[13:0]; // see RULE_06
                    end else if (addr[3:2] == sweep_pkg::ASEL_BURST_IVAL) begin
                        n.burst_ival = wr_word_i[13:0]; // see RULE_11
                    end
                end
            endcase
        end

        if (n.st == sweep_pkg::ST_IDLE) begin
            n.midscale = 1'b1; // see RULE_25
        end else if (cont) begin
            n.midscale = 1'b0; // see RULE_19
        end else if (ext_burst) begin
            n.midscale = ~trig_i; // see RULE_17
        end else begin
            n.midscale = ~n.burst_on; // see RULE_10
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s            <= '0;
            s.st         <= sweep_pkg::ST_IDLE;
            s.midscale   <= 1'b1;
            s.ctrl       <= sweep_pkg::CTRL_RESET;
            s.step_count <= sweep_pkg::COUNT_RESET;
            s.step_ival  <= sweep_pkg::IVAL_RESET;
            s.burst_ival <= sweep_pkg::IVAL_RESET;
        end else begin
            s <= n;
        end
    end
    assign freq_word_o    = s.cur;
    assign midscale_o     = s.midscale;
    assign sweep_active_o = running;
    assign step_pulse_o   = s.step_pulse;
    assign step_index_o   = s.idx;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_idle_quiet;
        (s.st == sweep_pkg::ST_IDLE) |-> (midscale_o && !step_pulse_o);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) // see RULE_25
        else $error("Idle sequencer left midscale or stepped");
    property p_start_first;
        $rose(sweep_active_o) |->
            (freq_word_o == $past(s.start_freq) && step_index_o == 12'h000);
    endproperty
    a_start_first: assert property (p_start_first) // see RULE_13
        else $error("Sweep did not begin at the start frequency");
    property p_step_add;
        (step_pulse_o && !$past(at_end) && !$past(sub)) |->
            (freq_word_o == $past(s.cur) + {1'b0, $past(s.fstep_mag)});
    endproperty
    a_step_add: assert property (p_step_add) // see RULE_03
        else $error("Upward step did not add the step size");
    property p_step_sub;
        (step_pulse_o && !$past(at_end) && $past(sub)) |->
            (freq_word_o == $past(s.cur) - {1'b0, $past(s.fstep_mag)});
    endproperty
    a_step_sub: assert property (p_step_sub) // see RULE_04
        else $error("Downward step did not subtract the step size");
    property p_saw_wrap;
        (step_pulse_o && $past(at_end) && $past(saw)) |->
            (freq_word_o == $past(s.start_freq) && step_index_o == 12'h000);
    endproperty
    a_saw_wrap: assert property (p_saw_wrap) // see RULE_24
        else $error("Saw sweep did not restart at the start frequency");
    property p_tri_turn;
        (step_pulse_o && $past(at_end) && !$past(saw)) |->
            (s.reverse != $past(s.reverse) && step_index_o == 12'h001);
    endproperty
    a_tri_turn: assert property (p_tri_turn) // see RULE_24
        else $error("Triangle sweep did not reverse at the end");
    property p_full_hold;
        (wr_valid_i && addr == sweep_pkg::ADDR_START_LOW && full_word) |=>
            (s.start_freq == $past(s.start_freq));
    endproperty
    a_full_hold: assert property (p_full_hold) // see RULE_23
        else $error("Start frequency changed on a lone low half");
    property p_full_commit;
        (wr_valid_i && addr == sweep_pkg::ADDR_START_HIGH && full_word) |=>
            (s.start_freq == {$past(data), $past(s.start_pend)});
    endproperty
    a_full_commit: assert property (p_full_commit) // see RULE_01
        else $error("Start frequency not committed from both halves");
    property p_split_low;
        (wr_valid_i && addr == sweep_pkg::ADDR_START_LOW && !full_word) |=>
            (s.start_freq[11:0] == $past(data)
             && s.start_freq[23:12] == $past(s.start_freq[23:12]));
    endproperty
    a_split_low: assert property (p_split_low) // see RULE_02
        else $error("Split low write disturbed the high half");
    property p_ext_step;
        (running && ext_step && trig_rise && !wr_valid_i) |=> step_pulse_o;
    endproperty
    a_ext_step: assert property (p_ext_step) // see RULE_15
        else $error("Trigger edge did not advance the frequency");
    property p_auto_step;
        (step_pulse_o && !$past(ext_step)) |-> $past(step_expire);
    endproperty
    a_auto_step: assert property (p_auto_step) // see RULE_20
        else $error("Timed step came without interval expiry");
    property p_cont_out;
        (running && $past(cont)) |-> !midscale_o;
    endproperty
    a_cont_out: assert property (p_cont_out) // see RULE_19
        else $error("Continuous mode fell to midscale");
    property p_ext_gate;
        (running && $past(ext_burst)) |-> (midscale_o == !$past(trig_i));
    endproperty
    a_ext_gate: assert property (p_ext_gate) // see RULE_17
        else $error("External burst output does not follow trigger");
    property p_burst_end;
        (running && $past(running) && $past(burst_expire) && !$past(advance)
         && !$past(cont) && !$past(ext_burst)) |-> midscale_o;
    endproperty
    a_burst_end: assert property (p_burst_end) // see RULE_10
        else $error("Burst interval ended without midscale");
    c_saw_wrap: cover property (step_pulse_o && $past(at_end) && $past(saw));
    c_tri_turn: cover property (step_pulse_o && $past(at_end) && !$past(saw));
    c_ext_gate: cover property (running && $past(ext_burst) && $fell(midscale_o));
    c_burst_end: cover property (running && !cont && $rose(midscale_o));
endmodule
`default_nettype wire

/* File: hdl/sweep_interval_counter.sv */
// Down counter of base ticks; pulses once when the interval runs out.
// Assumes a count of at least 2; a count of zero never expires.
`timescale 1ns/10ps
`default_nettype none
module sweep_interval_counter (
    // Clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_n_i,
    // Control
    input  wire logic                          load_i,
    input  wire logic                          run_i,
    input  wire logic [sweep_pkg::IVAL_W-1:0]  count_i,
    input  wire logic                          tick_i,
    // Status
    output logic                               expire_o
);
    typedef struct packed {
        logic [sweep_pkg::IVAL_W-1:0] remain;
        logic                         busy;
        logic                         expire;
    } ival_state_t;

    ival_state_t s;
    ival_state_t n;

    always_comb begin
        n = s;
        n.expire = 1'b0;
        if (load_i) begin
            n.remain = count_i; // see RULE_07
            n.busy   = (count_i != '0);
        end else if (run_i && s.busy && tick_i) begin
            n.remain = s.remain - 11'h001;
            if (s.remain == 11'h001) begin
                n.busy   = 1'b0;
                n.expire = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign expire_o = s.expire;
endmodule
`default_nettype wire

/* File: hdl/sweep_pkg.sv */
// Constants and types shared by the frequency sweep sequencer files.
// Assumes 16-bit host words arrive already assembled, one per strobe.
package sweep_pkg;

    // Host word layout
    localparam int unsigned WORD_W  = 16;
    localparam int unsigned DATA_W  = 12;
    localparam int unsigned FREQ_W  = 24;
    localparam int unsigned STEP_W  = 23;
    localparam int unsigned IWORD_W = 14;
    localparam int unsigned IVAL_W  = 11;
    localparam int unsigned MCNT_W  = 9;

    // Register addresses in word bits 15..12
    localparam logic [3:0] ADDR_CTRL       = 4'h0;
    localparam logic [3:0] ADDR_STEP_COUNT = 4'h1;
    localparam logic [3:0] ADDR_FSTEP_LOW  = 4'h2;
    localparam logic [3:0] ADDR_FSTEP_HIGH = 4'h3;
    localparam logic [3:0] ADDR_START_LOW  = 4'hc;
    localparam logic [3:0] ADDR_START_HIGH = 4'hd;
    // Interval words decode on word bits 15..14 only
    localparam logic [1:0] ASEL_STEP_IVAL  = 2'h1;
    localparam logic [1:0] ASEL_BURST_IVAL = 2'h2;

    // Control field positions
    localparam int unsigned CTRL_FULL_WORD_BIT  = 11;
    localparam int unsigned CTRL_CONT_BIT       = 7;
    localparam int unsigned CTRL_EXT_BURST_BIT  = 6;
    localparam int unsigned CTRL_EXT_STEP_BIT   = 5;
    localparam int unsigned CTRL_SAW_BIT        = 4;
    // Step high word: direction flag
    localparam int unsigned FSTEP_DIR_BIT       = 11;
    // Interval word fields
    localparam int unsigned IVAL_BASE_BIT       = 13;
    localparam int unsigned IVAL_MULT_HI        = 12;
    localparam int unsigned IVAL_MULT_LO        = 11;

    // Reset values
    localparam logic [11:0] CTRL_RESET  = 12'h003;
    localparam logic [11:0] COUNT_RESET = 12'h002;
    localparam logic [13:0] IVAL_RESET  = 14'h0002;

    // Time-base multipliers, as master clock periods per tick
    localparam logic [MCNT_W-1:0] MULT_X1   = 9'h001;
    localparam logic [MCNT_W-1:0] MULT_X5   = 9'h005;
    localparam logic [MCNT_W-1:0] MULT_X100 = 9'h064;
    localparam logic [MCNT_W-1:0] MULT_X500 = 9'h1f4;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } sweep_state_t;

endpackage

/* File: hdl/sweep_tick_gen.sv */
// Time-base tick generator: one tick per base interval.
// Assumes out_cycle_i pulses once per output waveform cycle.
`timescale 1ns/10ps
`default_nettype none
module sweep_tick_gen (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       restart_i,
    input  wire logic       run_i,
    input  wire logic       clock_base_i,
    input  wire logic [1:0] mult_sel_i,
    input  wire logic       out_cycle_i,
    // Tick
    output logic            tick_o
);
    typedef struct packed {
        logic [sweep_pkg::MCNT_W-1:0] cnt;
        logic                         tick;
    } tick_state_t;

    tick_state_t                  s;
    tick_state_t                  n;
    logic [sweep_pkg::MCNT_W-1:0] limit;

    always_comb begin
        n = s;
        case (mult_sel_i)
            2'h0:    limit = sweep_pkg::MULT_X1;
            2'h1:    limit = sweep_pkg::MULT_X5;
            2'h2:    limit = sweep_pkg::MULT_X100;
            default: limit = sweep_pkg::MULT_X500;
        endcase
        n.tick = 1'b0;
        if (restart_i) begin
            n.cnt = '0;
        end else if (run_i && clock_base_i) begin
            // Multiplier scales only the master clock base, see RULE_08
            if (s.cnt == limit - 9'h001) begin
                n.cnt  = '0;
                n.tick = 1'b1;
            end else begin
                n.cnt = s.cnt + 9'h001;
            end
        end else if (run_i) begin
            n.tick = out_cycle_i; // see RULE_06
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick_o = s.tick;
endmodule
`default_nettype wire
